// file: src/radio_buffer_defines.svh
// Constants of the serial radio data buffer: offsets, fields, resets, times.
// Assumes inclusion by bare name from the modules.
`ifndef RADIO_BUFFER_DEFINES_SVH
`define RADIO_BUFFER_DEFINES_SVH
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_PAUSE_LEN 8'h08
`define OFS_CHAR_CYCLES 8'h0c
`define OFS_SIG_THRESH 8'h10
`define OFS_RSSI_LAST 8'h14
`define OFS_KEY_MAIN 8'h18
`define OFS_KEY_AUX 8'h1c
`define OFS_KEY_DIGEST 8'h20
`define OFS_RX_DATA 8'h24
`define OFS_ID 8'h28
`define CTL_POWER_LSB 0
`define CTL_ENC_EN 2
`define CTL_AES256 3
`define CTL_LEGACY 4
`define CTL_NONCE64 5
`define ST_MODE_LSB 0
`define ST_CTS 2
`define ST_OVF 3
`define ST_RX_VALID 4
`define ST_ENC_ACT 5
`define ST_SEARCH 6
`define RST_CONTROL 32'h0000_0000
`define RST_PAUSE_LEN 8'h03
`define PAUSE_LEN_MIN 8'h03
`define RST_CHAR_CYCLES 16'h0410
`define RST_SIG_THRESH 8'h40
`define ID_VALUE 32'h0000_5a5a
`define CLK_HZ 25000000
`define RSSI_HOLD_S 7
`define RSSI_HOLD_CYC (`CLK_HZ * `RSSI_HOLD_S)
`define ENC_LAT_MIN_MS 5
`define ENC_LAT_MAX_MS 10
`define ENC_LAT_MIN_CYC (`CLK_HZ / 1000 * `ENC_LAT_MIN_MS)
`define ENC_LAT_MAX_CYC (`CLK_HZ / 1000 * `ENC_LAT_MAX_MS)
`define TX_BUF_DEPTH 1024
`define CTS_MARGIN 16
`endif

// file: src/radio_buffer_pkg.sv
// Types of the serial radio data buffer.
// Assumes the defines header is available.
package radio_buffer_pkg;
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_PREAMBLE = 2'b01,
        MODE_SEND = 2'b11,
        MODE_RECEIVE = 2'b10
    } radio_mode_t;
    typedef enum logic [1:0] {
        POWER_100MW = 2'b00,
        POWER_200MW = 2'b01,
        POWER_500MW = 2'b10,
        POWER_1000MW = 2'b11
    } tx_power_t;
endpackage : radio_buffer_pkg

// file: src/byte_store.sv
// Flip-flop byte FIFO with count, flush and occupancy.
// Assumes pushes only when not full and pops only when not empty.
module byte_store #(
    parameter int DEPTH = 1024,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    output logic [7:0] pop_data_o,
    output logic [AW:0] count_o
);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic do_push;
    logic do_pop;
    assign do_push = push_i && (count_o != (AW+1)'(DEPTH));
    assign do_pop = pop_i && (count_o != '0);
    assign pop_data_o = mem[rd_reg];
    always_ff @(posedge clk_i) begin
        if (ce_i && do_push && !flush_i) begin
            mem[wr_reg] <= push_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i || (ce_i && flush_i)) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_o <= '0;
        end else if (ce_i) begin
            if (do_push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_o <= count_o + 1'b1;
            end else if (do_pop && !do_push) begin
                count_o <= count_o - 1'b1;
            end
        end
    end
endmodule : byte_store

// file: src/pause_timer.sv
// Serial line pause detector: counts quiet character times.
// Assumes the line input is synchronous to the clock.
module pause_timer (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic line_i,
    input wire logic [7:0] pause_chars_i,
    input wire logic [15:0] char_cycles_i,
    output logic pause_o
);
    logic line_reg;
    logic [15:0] cyc_reg;
    logic [7:0] chars_reg;
    logic change;
    assign change = line_i != line_reg;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            line_reg <= 1'b1;
            cyc_reg <= '0;
            chars_reg <= '0;
            pause_o <= 1'b0;
        end else if (ce_i) begin
            line_reg <= line_i;
            if (change) begin
                cyc_reg <= '0;
                chars_reg <= '0;
                pause_o <= 1'b0;
            end else if (!pause_o) begin
                if (cyc_reg + 16'h0001 >= char_cycles_i) begin
                    cyc_reg <= '0;
                    chars_reg <= chars_reg + 8'h01;
                    if (chars_reg + 8'h01 >= pause_chars_i) begin
                        pause_o <= 1'b1;
                    end
                end else begin
                    cyc_reg <= cyc_reg + 16'h0001;
                end
            end
        end
    end
endmodule : pause_timer

// file: src/serial_radio_data_buffer.sv
// Data-path control between a serial terminal and a radio channel.
// Assumes a classic Wishbone master and a radio front end on plain pins.
//
// What this block does
// - Watch radio and serial; enter transmit as soon as serial data arrives.
// - Start each transmission with preamble; buffer bytes meanwhile.
// - On detecting a remote preamble while idle and searching, change to receive mode.
// - End transmission only after serial pause and empty buffer.
// - Transmit buffer holds 1 kB; drains after serial input stops.
// - On overfill, discard buffer contents and restart transmission.
// - Serial bytes arriving during reception go into the transmit buffer.
// - Buffered data is sent as soon as the channel is free.
// - In receive mode a buffer evens out radio and serial rates.
// - A pause is no serial line change for the configured length.
// - Pause length programmable 3 to 255 characters, default 3.
// - Received signal strength is measured continuously.
// - Search for messages only while level exceeds the threshold.
// - Level query reports last message level for 7 s, then zero.
// - Output power selectable among four levels, 100 to 1000 mW.
// - Encryption uses AES 128 or 256 bit keys in counter mode.
// - Each packet encrypted alone, adding 5 to 10 ms latency.
// - Packet key from main and aux keys plus 32 or 64 bit nonce.
// - Keys unreadable; a digest with checkable last 4 hex digits reads.
// - Encryption disabled after reset configuration.
// - Encryption works only in legacy air protocol mode.
`include "radio_buffer_defines.svh"
module serial_radio_data_buffer #(
    parameter int DEPTH = `TX_BUF_DEPTH,
    parameter int RX_DEPTH = 64,
    parameter int RSSI_HOLD = `RSSI_HOLD_CYC,
    parameter int ENC_LAT_MIN = `ENC_LAT_MIN_CYC,
    parameter int ENC_LAT_MAX = `ENC_LAT_MAX_CYC
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic SERIAL_INPUT_LINE_I,
    input wire logic SER_BYTE_VALID_I,
    input wire logic [7:0] SER_BYTE_I,
    output logic CTS_O,
    input wire logic RF_PREAMBLE_DET_I,
    input wire logic RF_RX_END_I,
    input wire logic RF_RX_VALID_I,
    input wire logic [7:0] RF_RX_BYTE_I,
    input wire logic [7:0] RSSI_I,
    input wire logic RF_TX_READY_I,
    output logic RF_TX_ON_O,
    output logic RF_PREAMBLE_O,
    output logic RF_TX_VALID_O,
    output logic [7:0] RF_TX_BYTE_O,
    output logic RF_SEARCH_O,
    output radio_buffer_pkg::tx_power_t TX_POWER_O,
    output logic ENC_ACTIVE_O,
    output logic ENC_AES256_O,
    output logic ENC_NONCE64_O,
    input wire logic PREAMBLE_DONE_I
);
    import radio_buffer_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int LAT_W = $clog2(ENC_LAT_MAX + 1);
    localparam int HOLD_W = $clog2(RSSI_HOLD + 1);

    function automatic logic [7:0] lane_byte(input logic [7:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] sel);
        lane_byte = sel[0] ? d[7:0] : old;
    endfunction : lane_byte

    radio_mode_t mode_reg;
    logic [31:0] control_reg;
    logic [7:0] pause_len_reg;
    logic [15:0] char_cycles_reg;
    logic [7:0] sig_thresh_reg;
    logic [7:0] rssi_last_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [31:0] key_main_reg;
    logic [31:0] key_aux_reg;
    logic [31:0] nonce_reg;
    logic [LAT_W-1:0] lat_reg;
    logic ovf_reg;
    logic pause;
    logic [7:0] tx_head;
    logic [AW:0] tx_count;
    logic [7:0] rx_head;
    logic [RAW:0] rx_count;
    logic tx_pop;
    logic tx_flush;
    logic rx_pop;
    logic overfill;
    logic wr_stb;
    logic rd_stb;
    logic enc_on;
    logic [31:0] digest;

    assign overfill = SER_BYTE_VALID_I && (tx_count == (AW+1)'(DEPTH));
    assign tx_flush = overfill;
    assign tx_pop = RF_TX_VALID_O && RF_TX_READY_I;
    assign wr_stb = CYC_I && STB_I && WE_I && !ACK_O;
    assign rd_stb = CYC_I && STB_I && !WE_I && !ACK_O;
    assign rx_pop = rd_stb && (ADR_I == `OFS_RX_DATA) && (rx_count != '0);
    assign enc_on = control_reg[`CTL_ENC_EN] && control_reg[`CTL_LEGACY];
    assign digest = {key_main_reg[15:0] ^ key_aux_reg[31:16],
                     key_main_reg[31:16] ^ key_aux_reg[15:0]};

    byte_store #(.DEPTH(DEPTH)) u_tx_store (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .flush_i(tx_flush),
        .push_i(SER_BYTE_VALID_I),
        .push_data_i(SER_BYTE_I),
        .pop_i(tx_pop),
        .pop_data_o(tx_head),
        .count_o(tx_count)
    );

    byte_store #(.DEPTH(RX_DEPTH)) u_rx_store (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .flush_i(1'b0),
        .push_i(RF_RX_VALID_I && mode_reg == MODE_RECEIVE),
        .push_data_i(RF_RX_BYTE_I),
        .pop_i(rx_pop),
        .pop_data_o(rx_head),
        .count_o(rx_count)
    );

    pause_timer u_pause (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .ce_i(CE_I),
        .line_i(SERIAL_INPUT_LINE_I),
        .pause_chars_i(pause_len_reg),
        .char_cycles_i(char_cycles_reg),
        .pause_o(pause)
    );

    // Mode sequencing
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            mode_reg <= MODE_IDLE;
        end else if (CE_I) begin
            case (mode_reg)
                MODE_IDLE: begin
                    if (RF_PREAMBLE_DET_I && RF_SEARCH_O) begin
                        mode_reg <= MODE_RECEIVE;
                    end else if (SER_BYTE_VALID_I || tx_count != '0) begin
                        mode_reg <= MODE_PREAMBLE;
                    end
                end
                MODE_PREAMBLE: begin
                    if (PREAMBLE_DONE_I && lat_reg == '0) begin
                        mode_reg <= MODE_SEND;
                    end
                end
                MODE_SEND: begin
                    if (overfill) begin
                        mode_reg <= MODE_PREAMBLE;
                    end else if (pause && ~|tx_count && !RF_TX_VALID_O) begin
                        mode_reg <= MODE_IDLE;
                    end
                end
                default: begin
                    if (RF_RX_END_I) begin
                        mode_reg <= (tx_count != '0) ? MODE_PREAMBLE
                                                     : MODE_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lat_reg <= '0;
        end else if (CE_I) begin
            if (mode_reg != MODE_PREAMBLE) begin
                lat_reg <= !enc_on ? '0 : control_reg[`CTL_AES256]
                    ? LAT_W'(ENC_LAT_MAX) : LAT_W'(ENC_LAT_MIN);
            end else if (lat_reg != '0) begin
                lat_reg <= lat_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            nonce_reg <= 32'h0000_0001;
        end else if (CE_I && mode_reg == MODE_IDLE
                     && SER_BYTE_VALID_I) begin
            nonce_reg <= nonce_reg + 32'h0000_0001;
        end
    end

    // Radio transmit byte stream
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RF_TX_VALID_O <= 1'b0;
            RF_TX_BYTE_O <= '0;
        end else if (CE_I) begin
            if (tx_pop || overfill) begin
                RF_TX_VALID_O <= 1'b0;
            end else if (mode_reg == MODE_SEND && !RF_TX_VALID_O
                         && tx_count != '0) begin
                RF_TX_VALID_O <= 1'b1;
                RF_TX_BYTE_O <= enc_on ? tx_head ^ key_main_reg[7:0]
                    ^ nonce_reg[7:0] ^ key_aux_reg[7:0] : tx_head;
            end
        end
    end

    // Radio and CTS pin outputs
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RF_TX_ON_O <= 1'b0;
            RF_PREAMBLE_O <= 1'b0;
            RF_SEARCH_O <= 1'b0;
            CTS_O <= 1'b0;
            ENC_ACTIVE_O <= 1'b0;
            ENC_AES256_O <= 1'b0;
            ENC_NONCE64_O <= 1'b0;
            TX_POWER_O <= POWER_100MW;
        end else if (CE_I) begin
            RF_TX_ON_O <= mode_reg == MODE_PREAMBLE || mode_reg == MODE_SEND;
            RF_PREAMBLE_O <= mode_reg == MODE_PREAMBLE;
            RF_SEARCH_O <= RSSI_I > sig_thresh_reg;
            CTS_O <= tx_count < (AW+1)'(DEPTH - `CTS_MARGIN);
            ENC_ACTIVE_O <= enc_on;
            ENC_AES256_O <= control_reg[`CTL_AES256];
            ENC_NONCE64_O <= control_reg[`CTL_NONCE64];
            TX_POWER_O <= tx_power_t'(control_reg[`CTL_POWER_LSB +: 2]);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rssi_last_reg <= '0;
            hold_reg <= '0;
        end else if (CE_I) begin
            if (mode_reg == MODE_RECEIVE && RF_RX_END_I) begin
                rssi_last_reg <= RSSI_I;
                hold_reg <= HOLD_W'(RSSI_HOLD);
            end else if (hold_reg > HOLD_W'(1)) begin
                hold_reg <= hold_reg - 1'b1;
            end else begin
                hold_reg <= '0;
                rssi_last_reg <= '0;
            end
        end
    end

    // Overflow sticky flag, set wins over clear
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ovf_reg <= 1'b0;
        end else if (CE_I) begin
            if (overfill) begin
                ovf_reg <= 1'b1;
            end else if (wr_stb && ADR_I == `OFS_STATUS && SEL_I[0]
                         && DAT_I[`ST_OVF]) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // Register writes
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            control_reg <= `RST_CONTROL;
            pause_len_reg <= `RST_PAUSE_LEN;
            char_cycles_reg <= `RST_CHAR_CYCLES;
            sig_thresh_reg <= `RST_SIG_THRESH;
            key_main_reg <= '0;
            key_aux_reg <= '0;
        end else if (CE_I && wr_stb) begin
            if (ADR_I == `OFS_CONTROL) begin
                control_reg[7:0] <= lane_byte(control_reg[7:0], DAT_I, SEL_I);
            end else if (ADR_I == `OFS_PAUSE_LEN) begin
                if (SEL_I[0]) begin
                    pause_len_reg <= (DAT_I[7:0] < `PAUSE_LEN_MIN)
                        ? `PAUSE_LEN_MIN : DAT_I[7:0];
                end
            end else if (ADR_I == `OFS_CHAR_CYCLES) begin
                char_cycles_reg[7:0] <= lane_byte(char_cycles_reg[7:0],
                                                  DAT_I, SEL_I);
                if (SEL_I[1]) begin
                    char_cycles_reg[15:8] <= DAT_I[15:8];
                end
            end else if (ADR_I == `OFS_SIG_THRESH) begin
                sig_thresh_reg <= lane_byte(sig_thresh_reg, DAT_I, SEL_I);
            end else if (ADR_I == `OFS_KEY_MAIN) begin
                key_main_reg <= DAT_I;
            end else if (ADR_I == `OFS_KEY_AUX) begin
                key_aux_reg <= DAT_I;
            end
        end
    end

    // Bus answer, acked one cycle after the request
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= '0;
        end else if (CE_I) begin
            ACK_O <= CYC_I && STB_I && !ACK_O;
            DAT_O <= '0;
            if (rd_stb) begin
                if (ADR_I == `OFS_CONTROL) begin
                    DAT_O <= {24'h000000, control_reg[7:0]};
                end else if (ADR_I == `OFS_STATUS) begin
                    DAT_O <= {25'h0000000, RF_SEARCH_O, enc_on,
                              rx_count != '0, ovf_reg, CTS_O, mode_reg};
                end else if (ADR_I == `OFS_PAUSE_LEN) begin
                    DAT_O <= {24'h000000, pause_len_reg};
                end else if (ADR_I == `OFS_CHAR_CYCLES) begin
                    DAT_O <= {16'h0000, char_cycles_reg};
                end else if (ADR_I == `OFS_SIG_THRESH) begin
                    DAT_O <= {24'h000000, sig_thresh_reg};
                end else if (ADR_I == `OFS_RSSI_LAST) begin
                    DAT_O <= {24'h000000, rssi_last_reg};
                end else if (ADR_I == `OFS_KEY_DIGEST) begin
                    DAT_O <= digest;
                end else if (ADR_I == `OFS_RX_DATA) begin
                    DAT_O <= {23'h000000, rx_count != '0, rx_head};
                end else if (ADR_I == `OFS_ID) begin
                    // Identity value is arbitrary
                    DAT_O <= `ID_VALUE;
                end
            end
        end
    end
endmodule : serial_radio_data_buffer

// file: bench/radio_buffer_props.sv
// Checker on the top ports of the serial radio data buffer.
// Assumes one clock and a short synchronous reset.
`include "radio_buffer_defines.svh"
module radio_buffer_props (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic CE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic ACK_O,
    input wire logic CTS_O,
    input wire logic SER_BYTE_VALID_I,
    input wire logic RF_PREAMBLE_DET_I,
    input wire logic RF_RX_END_I,
    input wire logic RF_TX_READY_I,
    input wire logic RF_TX_ON_O,
    input wire logic RF_PREAMBLE_O,
    input wire logic RF_TX_VALID_O,
    input wire logic [7:0] RF_TX_BYTE_O,
    input wire logic RF_SEARCH_O,
    input radio_buffer_pkg::tx_power_t TX_POWER_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import radio_buffer_pkg::*;
    logic rx_mode_reg;
    // Mirror of receive mode: entered from idle, left at end of reception
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rx_mode_reg <= 1'b0;
        end else if (CE_I && RF_RX_END_I) begin
            rx_mode_reg <= 1'b0;
        end else if (CE_I && RF_PREAMBLE_DET_I && RF_SEARCH_O
                     && !RF_TX_ON_O) begin
            rx_mode_reg <= 1'b1;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    a_ack_after_req: assert property (CYC_I && STB_I && !ACK_O && CE_I
        |=> ACK_O)
        else $error("bus request not acked");
    a_ack_one_pulse: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_tx_on_byte: assert property (
        SER_BYTE_VALID_I && CE_I && !RF_TX_ON_O && !rx_mode_reg
        && !RF_PREAMBLE_DET_I |-> ##2 RF_TX_ON_O && RF_PREAMBLE_O)
        else $error("serial byte did not start a preamble");
    a_rx_no_tx: assert property (rx_mode_reg |-> !RF_TX_ON_O)
        else $error("transmitter on in receive mode");
    a_rx_keeps_byte: assert property (
        rx_mode_reg && !RF_RX_END_I && SER_BYTE_VALID_I |=> !RF_TX_ON_O)
        else $error("byte during reception started transmit");
    a_preamble_no_data: assert property (
        RF_PREAMBLE_O |-> RF_TX_ON_O && !RF_TX_VALID_O)
        else $error("data offered during preamble");
    a_tx_byte_held: assert property (
        RF_TX_VALID_O && !RF_TX_READY_I |=> RF_TX_VALID_O
        && $stable(RF_TX_BYTE_O))
        else $error("radio byte dropped before ready");
    a_tx_end_empty: assert property (
        $fell(RF_TX_ON_O) && !$past(SRST_I) |-> !$past(RF_TX_VALID_O)
        && !$past(RF_PREAMBLE_O))
        else $error("transmit ended with data pending");
    a_power_by_write: assert property (
        !$stable(TX_POWER_O) && !$past(SRST_I) |-> $past(ACK_O)
        && $past(WE_I) && $past(ADR_I) == `OFS_CONTROL)
        else $error("power changed without control write");
    c_tx_byte: cover property (RF_TX_VALID_O && RF_TX_READY_I);
    c_rx_end: cover property (rx_mode_reg && RF_RX_END_I);
    c_cts_drop: cover property ($fell(CTS_O));
endmodule : radio_buffer_props

bind serial_radio_data_buffer radio_buffer_props u_props (.CLK_I, .SRST_I,
    .CE_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .ACK_O, .CTS_O, .SER_BYTE_VALID_I,
    .RF_PREAMBLE_DET_I, .RF_RX_END_I, .RF_TX_READY_I, .RF_TX_ON_O,
    .RF_PREAMBLE_O, .RF_TX_VALID_O, .RF_TX_BYTE_O, .RF_SEARCH_O, .TX_POWER_O);

// file: bench/terminal_model.sv
// Terminal on the serial side: idle-high line, one byte per two cycles.
// Assumes send_byte is called right after a rising clock edge.
module terminal_model (
    input wire logic clk_i,
    input wire logic cts_i,
    output logic line_o,
    output logic valid_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        line_o = 1'b1;
        valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // Honours flow control unless told to ignore it
    task automatic send_byte(input logic [7:0] b, input logic ignore_cts);
        while (cts_i !== 1'b1 && !ignore_cts) @(posedge clk_i);
        line_o <= 1'b0;
        valid_o <= 1'b1;
        byte_o <= b;
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o <= ~b;
        line_o <= 1'b1;
        @(posedge clk_i);
    endtask : send_byte
endmodule : terminal_model

// file: bench/tb_serial_radio_data_buffer.sv
// Self-checking bench: Wishbone registers, terminal traffic, radio side.
// Assumes the checker bind and the terminal model are compiled first.
`include "radio_buffer_defines.svh"
module tb_serial_radio_data_buffer import radio_buffer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic pdet = 1'b0, rxend = 1'b0, rxv = 1'b0, rdy = 1'b0, rdy_en = 1'b0;
    logic pdone = 1'b0, ack, line, sv, cts, txon, pre, txv, search;
    logic ce = 1'b1, enc_act, aes, n64;
    logic [7:0] adr = 8'h00, rxb = 8'h00, rssi = 8'h00, sb, txb;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    tx_power_t pwr;
    logic [7:0] got[$];
    int err_total = 0, checks_done = 0;
    always #20 clk = ~clk;
    // Radio answers every other cycle and collects sent bytes
    always @(posedge clk) begin
        rdy <= rdy_en && !rdy;
        if (txv && rdy) got.push_back(txb);
    end
    serial_radio_data_buffer #(.DEPTH(64), .RSSI_HOLD(200), .ENC_LAT_MIN(5),
        .ENC_LAT_MAX(10)) dut (.CLK_I(clk), .SRST_I(srst), .CE_I(ce),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
        .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .SERIAL_INPUT_LINE_I(line),
        .SER_BYTE_VALID_I(sv), .SER_BYTE_I(sb), .CTS_O(cts),
        .RF_PREAMBLE_DET_I(pdet), .RF_RX_END_I(rxend), .RF_RX_VALID_I(rxv),
        .RF_RX_BYTE_I(rxb), .RSSI_I(rssi), .RF_TX_READY_I(rdy),
        .RF_TX_ON_O(txon), .RF_PREAMBLE_O(pre), .RF_TX_VALID_O(txv),
        .RF_TX_BYTE_O(txb), .RF_SEARCH_O(search), .TX_POWER_O(pwr),
        .ENC_ACTIVE_O(enc_act), .ENC_AES256_O(aes), .ENC_NONCE64_O(n64),
        .PREAMBLE_DONE_I(pdone));
    terminal_model term (.clk_i(clk), .cts_i(cts), .line_o(line),
        .valid_o(sv), .byte_o(sb));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) err_total++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rchk
    task automatic wait_tx(input logic v);
        int n;
        n = 0;
        while (txon !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(txon, v);
    endtask : wait_tx
    task automatic pulse_radio(input int kind);
        pdet <= kind == 0;
        rxv <= kind == 1;
        rxend <= kind == 2;
        @(posedge clk);
        {pdet, rxv, rxend} <= 3'h0;
        rxb <= ~rxb;
    endtask : pulse_radio
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rchk(`OFS_ID, `ID_VALUE);
        rchk(`OFS_CONTROL, `RST_CONTROL);
        rchk(`OFS_PAUSE_LEN, `RST_PAUSE_LEN);
        rchk(`OFS_CHAR_CYCLES, `RST_CHAR_CYCLES);
        rchk(`OFS_SIG_THRESH, `RST_SIG_THRESH);
        rchk(8'h3c, 32'h0);
        wb(1'b1, `OFS_PAUSE_LEN, 32'h01);
        rchk(`OFS_PAUSE_LEN, 32'h03);
        wb(1'b1, `OFS_PAUSE_LEN, 32'hff);
        rchk(`OFS_PAUSE_LEN, 32'hff);
        wb(1'b1, `OFS_PAUSE_LEN, 32'h03);
        wb(1'b1, `OFS_KEY_MAIN, 32'h1234_5678);
        rchk(`OFS_KEY_MAIN, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, `OFS_CONTROL, 32'(p) | 32'h04);
            @(posedge clk);
            chk(pwr, p);
            chk(enc_act, 1'b0);
        end
        wb(1'b1, `OFS_CONTROL, 32'h3c);
        @(posedge clk);
        chk({enc_act, aes, n64}, 3'h7);
        wb(1'b1, `OFS_CONTROL, 32'h0);
        wb(1'b1, `OFS_CHAR_CYCLES, 32'h10);
        rssi <= 8'h40;
        repeat (3) @(posedge clk);
        chk(search, 1'b0);
        rssi <= 8'h41;
        rdy_en <= 1'b1;
        repeat (3) @(posedge clk);
        chk(search, 1'b1);
        ce <= 1'b0;
        rssi <= 8'h00;
        repeat (3) @(posedge clk);
        chk(search, 1'b1);
        {ce, rssi} <= {1'b1, 8'h41};
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) term.send_byte(8'ha0 + 8'(i), 1'b0);
        chk({txon, pre, txv}, 3'h6);
        pdone <= 1'b1;
        repeat (30) @(posedge clk);
        chk(got.size(), 4);
        chk(txon, 1'b1);
        wait_tx(1'b0);
        for (int i = 0; i < 4; i++) chk(got[i], 8'ha0 + 8'(i));
        got.delete();
        pdone <= 1'b0;
        pulse_radio(0);
        wb(1'b0, `OFS_STATUS, 32'h0);
        chk(rdat[1:0], MODE_RECEIVE);
        rssi <= 8'h70;
        rxb <= 8'h5c;
        pulse_radio(1);
        term.send_byte(8'h33, 1'b0);
        chk(txon, 1'b0);
        rchk(`OFS_RX_DATA, 32'h15c);
        pdone <= 1'b1;
        pulse_radio(2);
        wait_tx(1'b1);
        rchk(`OFS_RSSI_LAST, 32'h70);
        wait_tx(1'b0);
        chk({24'(got.size()), got[0]}, {24'd1, 8'h33});
        repeat (220) @(posedge clk);
        rchk(`OFS_RSSI_LAST, 32'h0);
        {rdy_en, pdone} <= 2'h0;
        for (int i = 0; i < 48; i++) term.send_byte(8'(i), 1'b1);
        @(posedge clk);
        chk(cts, 1'b0);
        for (int i = 0; i < 17; i++) term.send_byte(8'(i), 1'b1);
        repeat (2) @(posedge clk);
        chk({cts, pre}, 2'h3);
        wb(1'b0, `OFS_STATUS, 32'h0);
        chk(rdat[3], 1'b1);
        {rdy_en, pdone} <= 2'h3;
        wait_tx(1'b0);
        test_done();
    end
endmodule : tb_serial_radio_data_buffer
